// File: design/ata_cmd_pkg.sv
// constants for the command decoder: opcodes, subcodes, classes, register map
// assumes a 32-bit AXI4-Lite register port and one 40 MHz clock
package ata_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TASKFILE = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ERROR = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;
  localparam logic [7:0] OFS_DRIVE = 8'h18;
  localparam logic [7:0] OFS_DONE = 8'h1C;
  // taskfile field positions: feature, sector count, device/head
  localparam int FEAT_LSB = 0;
  localparam int SCNT_LSB = 8;
  localparam int DEVH_LSB = 16;
  localparam int DEV_BIT = 4;
  localparam int LBA_BIT = 6;
  localparam int OPT_BIT = 0;
  // status and error bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_COR = 2;
  localparam int ST_IDX = 1;
  localparam int ST_ERR = 0;
  localparam int ER_ABT = 2;
  // reset values, power query results, ECC byte counts
  localparam logic [7:0] STATUS_RST = 8'h50;
  localparam logic [7:0] ERROR_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] PWR_AT_SPEED = 8'hFF;
  localparam logic [7:0] PWR_STOPPED = 8'h00;
  localparam logic [7:0] ECC_LONG = 8'h28;
  localparam logic [7:0] ECC_SHORT = 8'h04;
  // config register bit positions
  localparam int CF_WCACHE = 0;
  localparam int CF_LOOKAHEAD = 1;
  localparam int CF_REVERT = 2;
  localparam int CF_RELINT = 3;
  localparam int CF_ECC40 = 4;
  // timing: busy hold of a non-data command, ns
  localparam int CLK_NS = 25;
  localparam int BUSY_NS = 100;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  // opcodes
  localparam logic [7:0] OP_VERIFY_R = 8'h40;
  localparam logic [7:0] OP_VERIFY_NR = 8'h41;
  localparam logic [3:0] OP_RECAL_HI = 4'h1;
  localparam logic [3:0] OP_SEEK_HI = 4'h7;
  localparam logic [7:0] OP_SMART = 8'hB0;
  localparam logic [7:0] OP_SETFEAT = 8'hEF;
  localparam logic [7:0] OP_SETMAX = 8'hF9;
  localparam logic [7:0] OP_PWRCHK = 8'hE5;
  localparam logic [7:0] OP_PWRCHK_ALT = 8'h98;
  localparam logic [7:0] OP_DIAG = 8'h90;
  localparam logic [7:0] OP_FLUSH = 8'hE7;
  localparam logic [7:0] OP_STANDBY = 8'hE2;
  localparam logic [7:0] OP_STANDBY_ALT = 8'h96;
  localparam logic [7:0] OP_STBYI = 8'hE0;
  localparam logic [7:0] OP_STBYI_ALT = 8'h94;
  localparam logic [7:0] OP_SLEEP = 8'hE6;
  localparam logic [7:0] OP_SLEEP_ALT = 8'h99;
  localparam logic [7:0] OP_IDLE = 8'hE3;
  localparam logic [7:0] OP_IDLE_ALT = 8'h97;
  localparam logic [7:0] OP_IDLEI = 8'hE1;
  localparam logic [7:0] OP_IDLEI_ALT = 8'h95;
  // set-features and SMART subcodes
  localparam logic [7:0] SF_WC_ON = 8'h02;
  localparam logic [7:0] SF_XFER = 8'h03;
  localparam logic [7:0] SF_ECC40 = 8'h44;
  localparam logic [7:0] SF_LA_OFF = 8'h55;
  localparam logic [7:0] SF_REL_ON = 8'h5D;
  localparam logic [7:0] SF_REV_OFF = 8'h66;
  localparam logic [7:0] SF_WC_OFF = 8'h82;
  localparam logic [7:0] SF_LA_ON = 8'hAA;
  localparam logic [7:0] SF_ECC4 = 8'hBB;
  localparam logic [7:0] SF_REV_ON = 8'hCC;
  localparam logic [7:0] SF_REL_OFF = 8'hDD;
  localparam logic [7:0] SM_FIRST = 8'hD0;
  localparam logic [7:0] SM_LAST = 8'hDB;
  localparam logic [7:0] SM_HOLE = 8'hD7;
  localparam logic [7:0] SM_THRESH = 8'hD1;
  localparam logic [7:0] SM_RDLOG = 8'hD5;
  localparam logic [7:0] SM_WRLOG = 8'hD6;

  typedef enum logic [2:0] {
    CLS_NONE = 3'b000,
    CLS_PIO_IN = 3'b001,
    CLS_PIO_OUT = 3'b010,
    CLS_NODATA = 3'b011,
    CLS_DMA = 3'b100,
    CLS_QDMA = 3'b101
  } proto_class_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_SLEEP = 2'b10
  } pwr_mode_t;
endpackage

// File: design/ata_opcode_class.sv
// opcode and feature subcode to protocol class lookup
// assumes a pure combinational caller on the same clock
module ata_opcode_class (
  input wire logic [7:0] opcode,
  input wire logic [7:0] feature,
  output ata_cmd_pkg::proto_class_t cls,
  output logic retry_en
);
  import ata_cmd_pkg::*;

  always_comb
  begin
    retry_en = 1'b0;
    unique case (opcode[7:4])
      OP_RECAL_HI, OP_SEEK_HI: cls = CLS_NODATA;
      default:
      begin
        unique case (opcode)
          OP_VERIFY_R, OP_VERIFY_NR: cls = CLS_NODATA;
          8'h20, 8'h21, 8'h22, 8'h23, 8'hC4, 8'hE4, 8'hEC: cls = CLS_PIO_IN;
          8'h30, 8'h31, 8'hC5: cls = CLS_PIO_OUT;
          8'h32, 8'h33: cls = CLS_PIO_OUT;
          8'h50, 8'hE8, 8'hF1, 8'hF2, 8'hF4, 8'hF6: cls = CLS_PIO_OUT;
          8'hC8, 8'hC9, 8'hCA, 8'hCB: cls = CLS_DMA;
          8'hC7, 8'hCC, 8'hA2: cls = CLS_QDMA;
          OP_PWRCHK, OP_PWRCHK_ALT, OP_DIAG, OP_FLUSH: cls = CLS_NODATA;
          OP_STANDBY, OP_STANDBY_ALT, OP_STBYI, OP_STBYI_ALT: cls = CLS_NODATA;
          OP_SLEEP, OP_SLEEP_ALT, OP_IDLE, OP_IDLE_ALT: cls = CLS_NODATA;
          OP_IDLEI, OP_IDLEI_ALT, 8'h91, 8'h00, 8'hF8: cls = CLS_NODATA;
          8'hF3, 8'hF5, OP_SETMAX, 8'hC6: cls = CLS_NODATA;
          OP_SETFEAT:
          begin
            unique case (feature)
              SF_WC_ON, SF_XFER, SF_ECC40, SF_LA_OFF, SF_REL_ON, SF_REV_OFF,
              SF_WC_OFF, SF_LA_ON, SF_ECC4, SF_REV_ON, SF_REL_OFF: cls = CLS_NODATA;
              default: cls = CLS_NONE;
            endcase
          end
          OP_SMART:
          begin
            if (feature < SM_FIRST || feature > SM_LAST || feature == SM_HOLE)
              cls = CLS_NONE;
            else if (feature == SM_THRESH || feature == SM_RDLOG)
              cls = CLS_PIO_IN;
            else if (feature == SM_WRLOG)
              cls = CLS_PIO_OUT;
            else
              cls = CLS_NODATA;
          end
          default: cls = CLS_NONE;
        endcase
      end
    endcase
    // even opcode of a retry pair enables retries
    if (opcode == 8'h20 || opcode == 8'h22 || opcode == 8'h30 || opcode == 8'h32 ||
        opcode == 8'h40 || opcode == 8'hC8 || opcode == 8'hCA)
      retry_en = 1'b1;
  end
endmodule // ata_opcode_class

// File: design/ata_command_decoder.sv
// command decoder top: AXI4-Lite register slave, dispatch and status
// assumes media logic reports spindle, cache-flush and diagnostic results
// Contract
// - 40h/41h verify with/without retry, no data
// - 1x recalibrate, 7x seek, low nibble ignored
// - alternate power opcodes act as originals
// - B0h subcodes D0-DB except D7 decoded
// - features 44h selects 40, BBh 4 ECC bytes
// - features 55h disables, AAh enables look-ahead
// - features CCh enables, 66h disables default revert
// - write cache, transfer mode, release interrupt subcodes
// - every command gets one protocol class
// - respond only when device bit matches role
// - addressing bit zero CHS, one LBA
// - option bit examined only for set-max
// - even opcode retries on, odd opcode off
// - E5h and 98h are power-mode query
// - query returns FFh if spun up, else 00h; here FFh also needs active power mode, so standby or sleep gives 00h
// - 90h runs diagnostics regardless of device bit
// - after diagnostics error holds result code
// - E7h completes only after cache committed
// - status and error valid at completion interrupt
// - 30h/31h sector write, C5h multiple write
// - 32h/33h long write, CAh/CBh DMA write
// - busy on opcode, interrupt at end, status read clears; queued DMA raises no interrupt unless release interrupt is set
// - invalid parameter aborts with error and abort
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
module ata_command_decoder (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slave_role,
  input wire logic spindle_at_speed,
  input wire logic cache_flushed,
  input wire logic [7:0] diag_code,
  input wire logic media_fault,
  input wire logic index_pulse,
  output logic host_intrq,
  output logic cmd_start,
  output logic [7:0] cmd_opcode,
  output ata_cmd_pkg::proto_class_t cmd_class,
  output logic cmd_retry,
  output logic cmd_lba_mode,
  output logic cmd_max_option
);
  import ata_cmd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } cmd_state_t;

  logic [31:0] taskfile_ff;
  logic [7:0] status_ff, error_ff, result_ff, config_ff, opcode_ff;
  logic intrq_ff, start_ff, retry_ff, lba_ff, maxopt_ff;
  proto_class_t class_ff;
  pwr_mode_t pwr_ff;
  cmd_state_t state_ff;
  logic [7:0] busy_cnt_ff;
  logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic spin_s1_ff, spin_ff, flush_s1_ff, flush_ff, idx_s1_ff, idx_ff;
  logic flt_s1_ff, flt_ff;
  proto_class_t dec_class;
  logic dec_retry, wr_fire, cmd_write, status_read, selected;
  logic [7:0] feature;

  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction

  assign feature = taskfile_ff[FEAT_LSB +: 8];

  ata_opcode_class u_class (
    .opcode(wdata_ff[7:0]),
    .feature(feature),
    .cls(dec_class),
    .retry_en(dec_retry)
  );

  // pin synchronisers
  always_ff @(posedge clk_sys)
  begin
    spin_s1_ff <= spindle_at_speed;
    spin_ff <= spin_s1_ff;
    flush_s1_ff <= cache_flushed;
    flush_ff <= flush_s1_ff;
    idx_s1_ff <= index_pulse;
    idx_ff <= idx_s1_ff;
    flt_s1_ff <= media_fault;
    flt_ff <= flt_s1_ff;
  end

  // write channel capture
  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign wr_fire = aw_ff && w_ff && !bvalid_ff;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (awaddr_ff == OFS_TASKFILE || awaddr_ff == OFS_COMMAND ||
                     awaddr_ff == OFS_CONFIG) ? 2'b00 : 2'b10;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  assign selected = (taskfile_ff[DEVH_LSB + DEV_BIT] == slave_role);
  assign cmd_write = wr_fire && awaddr_ff == OFS_COMMAND &&
                     state_ff == ST_IDLE &&
                     (selected || wdata_ff[7:0] == OP_DIAG);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      taskfile_ff <= 32'h0000_0000;
    else if (wr_fire && awaddr_ff == OFS_TASKFILE && state_ff == ST_IDLE)
      taskfile_ff <= wr_merge(taskfile_ff, wdata_ff, wstrb_ff);
  end

  // read channel
  assign s_axi_arready = !rvalid_ff;
  assign status_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_STATUS;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= 2'b00;
      unique case (s_axi_araddr)
        OFS_TASKFILE: rdata_ff <= taskfile_ff;
        OFS_COMMAND: rdata_ff <= {21'h000000, class_ff, opcode_ff};
        OFS_STATUS: rdata_ff <= {24'h000000, status_ff};
        OFS_ERROR: rdata_ff <= {24'h000000, error_ff};
        OFS_RESULT: rdata_ff <= {24'h000000, result_ff};
        OFS_CONFIG: rdata_ff <= {24'h000000, config_ff};
        OFS_DRIVE: rdata_ff <= {30'h00000000, pwr_ff};
        OFS_DONE: rdata_ff <= {29'h00000000, maxopt_ff, lba_ff, retry_ff};
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= 2'b10;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // command sequencing
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_ff <= ST_IDLE;
      busy_cnt_ff <= 8'h00;
      opcode_ff <= 8'h00;
      class_ff <= CLS_NONE;
      retry_ff <= 1'b0;
      lba_ff <= 1'b0;
      maxopt_ff <= 1'b0;
      start_ff <= 1'b0;
    end
    else
    begin
      start_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
          if (cmd_write)
          begin
            opcode_ff <= wdata_ff[7:0];
            class_ff <= dec_class;
            retry_ff <= dec_retry;
            lba_ff <= taskfile_ff[DEVH_LSB + LBA_BIT];
            maxopt_ff <= (wdata_ff[7:0] == OP_SETMAX) &&
                         taskfile_ff[SCNT_LSB + OPT_BIT];
            start_ff <= (dec_class != CLS_NONE);
            busy_cnt_ff <= 8'(BUSY_CYC);
            state_ff <= ST_EXEC;
          end
        ST_EXEC:
          if (busy_cnt_ff > 8'h01)
            busy_cnt_ff <= busy_cnt_ff - 8'h01;
          else
            state_ff <= ST_WAIT;
        ST_WAIT:
          if (opcode_ff != OP_FLUSH || flush_ff)
            state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // completion, status, error, result and features
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      status_ff <= STATUS_RST;
      error_ff <= ERROR_RST;
      result_ff <= 8'h00;
      config_ff <= CONFIG_RST;
      pwr_ff <= PWR_ACTIVE;
      intrq_ff <= 1'b0;
    end
    else
    begin
      status_ff[ST_DF] <= flt_ff;
      status_ff[ST_IDX] <= idx_ff;
      status_ff[ST_DRQ] <= 1'b0;
      status_ff[ST_COR] <= 1'b0;
      if (cmd_write)
      begin
        status_ff[ST_BSY] <= 1'b1;
        status_ff[ST_ERR] <= 1'b0;
        error_ff <= 8'h00;
      end
      else if (state_ff == ST_WAIT && (opcode_ff != OP_FLUSH || flush_ff))
      begin
        status_ff[ST_BSY] <= 1'b0;
        status_ff[ST_DSC] <= 1'b1;
        intrq_ff <= config_ff[CF_RELINT] || class_ff != CLS_QDMA;
        if (class_ff == CLS_NONE)
        begin
          status_ff[ST_ERR] <= 1'b1;
          error_ff <= 8'h00 | (8'h01 << ER_ABT);
        end
        else
          unique case (opcode_ff)
            OP_PWRCHK, OP_PWRCHK_ALT:
              result_ff <= (spin_ff && pwr_ff == PWR_ACTIVE) ? PWR_AT_SPEED
                           : PWR_STOPPED;
            OP_DIAG: error_ff <= diag_code;
            OP_STANDBY, OP_STANDBY_ALT, OP_STBYI, OP_STBYI_ALT:
              pwr_ff <= PWR_STANDBY;
            OP_SLEEP, OP_SLEEP_ALT: pwr_ff <= PWR_SLEEP;
            OP_IDLE, OP_IDLE_ALT, OP_IDLEI, OP_IDLEI_ALT: pwr_ff <= PWR_ACTIVE;
            OP_SETFEAT:
              unique case (feature)
                SF_ECC40: config_ff[CF_ECC40] <= 1'b1;
                SF_ECC4: config_ff[CF_ECC40] <= 1'b0;
                SF_LA_OFF: config_ff[CF_LOOKAHEAD] <= 1'b0;
                SF_LA_ON: config_ff[CF_LOOKAHEAD] <= 1'b1;
                SF_REV_ON: config_ff[CF_REVERT] <= 1'b1;
                SF_REV_OFF: config_ff[CF_REVERT] <= 1'b0;
                SF_WC_ON: config_ff[CF_WCACHE] <= 1'b1;
                SF_WC_OFF: config_ff[CF_WCACHE] <= 1'b0;
                SF_REL_ON: config_ff[CF_RELINT] <= 1'b1;
                SF_REL_OFF: config_ff[CF_RELINT] <= 1'b0;
                default: result_ff <= taskfile_ff[SCNT_LSB +: 8];
              endcase
            default: result_ff <= result_ff;
          endcase
      end
      else if (status_read)
        intrq_ff <= 1'b0;
    end
  end

  assign host_intrq = intrq_ff;
  assign cmd_start = start_ff;
  assign cmd_opcode = opcode_ff;
  assign cmd_class = class_ff;
  assign cmd_retry = retry_ff;
  assign cmd_lba_mode = lba_ff;
  assign cmd_max_option = maxopt_ff;

  sequence cmd_taken_s;
    cmd_write && dec_class == CLS_NODATA;
  endsequence

  busy_on_cmd_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_write |=> status_ff[ST_BSY]) else $error("busy not set on command");
  abort_flags_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_write && dec_class == CLS_NONE |-> ##[1:10] (error_ff[ER_ABT] && status_ff[ST_ERR]))
    else $error("invalid command not aborted");
  nodata_done_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_taken_s ##1 (opcode_ff != OP_FLUSH) |-> ##[1:8] !status_ff[ST_BSY])
    else $error("non-data command never finished");
  verify_class_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_write && wdata_ff[7:1] == 7'h20 |=> class_ff == CLS_NODATA)
    else $error("verify not non-data");
  seek_class_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_write && wdata_ff[7:4] == OP_SEEK_HI |=> class_ff == CLS_NODATA)
    else $error("seek misclassed");
  retry_pair_a: assert property (@(posedge clk_sys) disable iff (srst)
    cmd_write && wdata_ff[7:0] == 8'hCB |=> !retry_ff && class_ff == CLS_DMA)
    else $error("odd opcode kept retry");
  flush_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    state_ff == ST_WAIT && opcode_ff == OP_FLUSH && !flush_ff |=> status_ff[ST_BSY])
    else $error("flush done before commit");
  deselect_a: assert property (@(posedge clk_sys) disable iff (srst)
    wr_fire && awaddr_ff == OFS_COMMAND && !selected && wdata_ff[7:0] != OP_DIAG
    |=> state_ff != ST_EXEC || $past(state_ff) != ST_IDLE)
    else $error("unselected device responded");
endmodule // ata_command_decoder

// File: verification/ata_host_model.sv
// host model: axi4-lite master loading the taskfile, writing opcodes, reading results
// assumes the decoder register map and a shared clk_sys
module ata_host_model (
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic host_intrq
);
  timeunit 1ns;
  timeprecision 1ps;
  import ata_cmd_pkg::*;
  initial
  begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // parameters first, opcode last; device, addressing and option bits chosen by caller
  task automatic issue(input logic [7:0] op, ft, sc, dh);
    logic [1:0] r;
    wr(OFS_TASKFILE, {8'h00, dh, sc, ft}, r);
    wr(OFS_COMMAND, {24'h000000, op}, r);
  endtask
  // waits for completion, then error and status; the status read clears intrq
  task automatic finish_cmd(output logic [7:0] st, er);
    logic [31:0] d;
    logic [1:0] r;
    while (host_intrq !== 1'b1)
      @(posedge clk_sys);
    rd(OFS_ERROR, d, r);
    er = d[7:0];
    rd(OFS_STATUS, d, r);
    st = d[7:0];
  endtask
endmodule // ata_host_model

// File: verification/ata_command_decoder_test.sv
// bench for the command decoder: opcode table, then reset and edge cases
// assumes ata_host_model drives the register port; media inputs set here
module ata_command_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ata_cmd_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] ft;
    logic [3:0] cl;
    logic [3:0] rt;
    logic [3:0] ab;
    logic [3:0] cb;
    logic [3:0] cv;
  } row_t;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic slave_role = 1'b0;
  logic spindle_at_speed = 1'b1;
  logic cache_flushed = 1'b1;
  logic [7:0] diag_code = 8'h00;
  logic media_fault = 1'b0;
  logic index_pulse = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, cmd_opcode, st, er;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, host_intrq, cmd_start;
  logic cmd_retry, cmd_lba_mode, cmd_max_option;
  proto_class_t cmd_class;
  int failures = 0;
  int compares = 0;
  int starts = 0;
  int n0;
  // op, feature, class, retry (2 = none), abort, config bit (F = none), config value
  row_t rows [43] = '{
    36'h40_00_3_1_0_F_0, 36'h41_00_3_0_0_F_0,
    36'h10_00_3_2_0_F_0, 36'h1F_00_3_2_0_F_0, 36'h70_00_3_2_0_F_0, 36'h7A_00_3_2_0_F_0,
    36'h96_00_3_2_0_F_0, 36'h94_00_3_2_0_F_0, 36'h97_00_3_2_0_F_0, 36'h95_00_3_2_0_F_0,
    36'hB0_D0_3_2_0_F_0, 36'hB0_D1_1_2_0_F_0, 36'hB0_D5_1_2_0_F_0, 36'hB0_D6_2_2_0_F_0,
    36'hB0_DA_3_2_0_F_0, 36'hB0_DB_3_2_0_F_0, 36'hB0_D7_0_2_1_F_0,
    36'hEF_44_3_2_0_4_1, 36'hEF_BB_3_2_0_4_0,
    36'hEF_55_3_2_0_1_0, 36'hEF_AA_3_2_0_1_1,
    36'hEF_CC_3_2_0_2_1, 36'hEF_66_3_2_0_2_0,
    36'hEF_02_3_2_0_0_1, 36'hEF_82_3_2_0_0_0, 36'hEF_03_3_2_0_F_0, 36'hEF_5D_3_2_0_3_1,
    36'hCC_00_5_2_0_F_0, 36'hEF_DD_3_2_0_3_0,
    36'hEF_13_0_2_1_F_0, 36'h8F_00_0_2_1_F_0,
    36'hE5_00_3_2_0_F_0, 36'h98_00_3_2_0_F_0, 36'h90_00_3_2_0_F_0, 36'hE7_00_3_2_0_F_0,
    36'h30_00_2_1_0_F_0, 36'h31_00_2_0_0_F_0, 36'hC5_00_2_2_0_F_0,
    36'h32_00_2_1_0_F_0, 36'h33_00_2_0_0_F_0, 36'hCA_00_4_1_0_F_0, 36'hCB_00_4_0_0_F_0,
    36'h99_00_3_2_0_F_0
  };
  ata_host_model host (
    .clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .host_intrq
  );
  ata_command_decoder uut (
    .clk_sys, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .slave_role, .spindle_at_speed, .cache_flushed, .diag_code, .media_fault,
    .index_pulse, .host_intrq, .cmd_start, .cmd_opcode, .cmd_class, .cmd_retry,
    .cmd_lba_mode, .cmd_max_option
  );
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (cmd_start === 1'b1)
      starts <= starts + 1;
  task automatic check(input logic [35:0] seen, exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
  endtask
  task automatic run(input logic [7:0] op, ft, sc, dh);
    host.issue(op, ft, sc, dh);
    host.finish_cmd(st, er);
  endtask
  task automatic pm(input logic [7:0] mode, query, exp);
    run(mode, 8'h00, 8'h00, 8'hA0);
    run(query, 8'h00, 8'h00, 8'hA0);
    host.rd(OFS_RESULT, rdv, rsp);
    check(rdv[7:0], exp, "power mode result");
  endtask
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      n0 = starts;
      run(rows[i].op, rows[i].ft, 8'h00, 8'hA0);
      check(st[ST_BSY], 1'b0, "busy at completion");
      check(st[ST_ERR], rows[i].ab[0], "error flag");
      check(er[ER_ABT], rows[i].ab[0], "abort flag");
      check(host_intrq, 1'b0, "intrq after status read");
      check(starts - n0, !rows[i].ab[0], "accept count");
      if (rows[i].ab[0] === 1'b0)
      begin
        check(cmd_class, rows[i].cl[2:0], "class");
        check(cmd_opcode, rows[i].op, "opcode");
      end
      if (rows[i].rt < 4'h2)
        check(cmd_retry, rows[i].rt[0], "retry");
      if (rows[i].cb != 4'hF)
      begin
        host.rd(OFS_CONFIG, rdv, rsp);
        check(rdv[rows[i].cb], rows[i].cv[0], "feature setting");
      end
    end
    do_reset();
    host.rd(OFS_STATUS, rdv, rsp);
    check(rdv[7:0], STATUS_RST, "status after reset");
    media_fault <= 1'b1;
    index_pulse <= 1'b1;
    repeat (4) @(posedge clk_sys);
    host.rd(OFS_STATUS, rdv, rsp);
    check(rdv[7:0], STATUS_RST | (8'h01 << ST_DF) | (8'h01 << ST_IDX), "fault, index");
    media_fault <= 1'b0;
    index_pulse <= 1'b0;
    host.rd(8'h20, rdv, rsp);
    check({rsp, rdv}, {2'b10, 32'h0}, "unmapped read");
    host.wr(8'h24, 32'h0, rsp);
    check(rsp, 2'b10, "unmapped write");
    pm(8'h95, 8'hE5, 8'hFF);
    pm(8'h94, 8'hE5, 8'h00);
    spindle_at_speed <= 1'b0;
    pm(8'hE1, 8'h98, 8'h00);
    spindle_at_speed <= 1'b1;
    pm(8'h97, 8'h98, 8'hFF);
    n0 = starts;
    host.issue(OP_PWRCHK, 8'h00, 8'h00, 8'hB0);
    repeat (20) @(posedge clk_sys);
    check({host_intrq, starts == n0}, 2'b01, "other unit ignored");
    slave_role <= 1'b1;
    run(OP_PWRCHK, 8'h00, 8'h00, 8'hB0);
    check(starts - n0, 1, "own unit accepted");
    diag_code <= 8'h81;
    run(OP_DIAG, 8'h00, 8'h00, 8'hA0);
    check(er, 8'h81, "diagnostic code");
    slave_role <= 1'b0;
    cache_flushed <= 1'b0;
    repeat (4) @(posedge clk_sys);
    host.issue(OP_FLUSH, 8'h00, 8'h00, 8'hA0);
    repeat (30) @(posedge clk_sys);
    host.rd(OFS_STATUS, rdv, rsp);
    check({rdv[ST_BSY], host_intrq}, 2'b10, "flush waits for cache");
    cache_flushed <= 1'b1;
    host.finish_cmd(st, er);
    check(st[ST_ERR], 1'b0, "flush good status");
    run(OP_SETMAX, 8'h00, 8'h01, 8'hE0);
    check({cmd_lba_mode, cmd_max_option}, 2'b11, "lba and option");
    run(OP_VERIFY_R, 8'h00, 8'h01, 8'hA0);
    check({cmd_lba_mode, cmd_max_option}, 2'b00, "chs, option ignored");
    wrap_up();
  end
endmodule // ata_command_decoder_test
